// file: rtl/serial_rom_mac_loader.sv
// serial rom controller: station address load and host rom operations
`timescale 1ns/1ps
module serial_rom_mac_loader
    import rom_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter int SCLK_HALF      = SCLK_HALF_CYC
) (
    // clock, reset, enable
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    // command register write
    input  wire logic        cmd_wr_in,
    input  wire logic [2:0]  cmd_op_in,
    input  wire logic [6:0]  cmd_loc_in,
    input  wire logic        cmd_busy_in,
    // data register write
    input  wire logic        data_wr_in,
    input  wire logic [7:0]  data_in,
    // station address writes by software
    input  wire logic        addr_low_wr_in,
    input  wire logic [31:0] addr_low_in,
    input  wire logic        addr_high_wr_in,
    input  wire logic [15:0] addr_high_in,
    // pin sharing
    input  wire logic        rom_if_disable_in,
    input  wire logic        gp_data_value_in,
    input  wire logic        gp_clock_value_in,
    // register views
    output logic             rom_busy_bit_out,
    output logic             rom_timeout_bit_out,
    output logic             rom_load_success_bit_out,
    output logic [2:0]       rom_operation_code_field_out,
    output logic [6:0]       rom_location_field_out,
    output logic [7:0]       serial_rom_data_reg_out,
    output logic [31:0]      station_address_low_reg_out,
    output logic [15:0]      station_address_high_reg_out,
    // rom pins
    output logic             rom_cs_out,
    output logic             rom_clock_pin_out,
    output logic             rom_data_pin_out,
    output logic             rom_data_pin_oe_out,
    input  wire logic        rom_data_pin_in
);
    localparam int CW = $clog2(TIMEOUT_CYCLES + 1);

    // ------------------------------
    // parameter checks
    // ------------------------------
    if (SCLK_HALF < 4 || SCLK_HALF > 255) begin : g_bad_half
        $error("serial clock half period out of range");
    end
    if (TIMEOUT_CYCLES < SCLK_HALF) begin : g_bad_to
        $error("timeout shorter than a serial clock phase");
    end

    typedef enum logic [3:0] {
        S_IDLE  = 4'b0001,
        S_SHIFT = 4'b0010,
        S_GAP   = 4'b0100,
        S_POLL  = 4'b1000
    } ctl_state_t;

    // ------------------------------
    // frame builder, used for address loads and host operations
    // ------------------------------
    function automatic logic [17:0] build_frame(input rom_op_t op,
                                                input logic [6:0] loc,
                                                input logic [7:0] dat);
        logic [1:0] opc;
        logic [6:0] a;
        opc = OPC_MISC;
        a   = loc;
        case (op)
            READ_CMD, RELOAD_CMD: opc = OPC_READ;
            WRITE_CMD:          opc = OPC_WRITE;
            ERASE_CMD:          opc = OPC_ERASE;
            FILL_ALL_CMD:       a = LOC_FILL;
            BULK_ERASE_CMD:     a = LOC_BULK;
            PROGRAM_UNLOCK_CMD: a = LOC_UNLOCK;
            PROGRAM_LOCK_CMD:   a = LOC_LOCK;
            default:            opc = OPC_MISC;
        endcase
        return {1'b1, opc, a, dat}; // start, opcode, 7-bit location
    endfunction

    // programming ops need the ready poll, and so the timeout
    function automatic logic is_prog(input rom_op_t op);
        return op inside {WRITE_CMD, FILL_ALL_CMD, ERASE_CMD, BULK_ERASE_CMD};
    endfunction

    // clock count per operation
    function automatic logic [4:0] bits_for(input rom_op_t op);
        if (op inside {READ_CMD, RELOAD_CMD, WRITE_CMD, FILL_ALL_CMD}) return 5'(LONG_BITS);
        return 5'(SHORT_BITS);
    endfunction

    rom_shift_if sh ();

    rom_serial_shifter #(
        .HALF_CYC (SCLK_HALF)
    ) u_shift (
        .mclk_in (mclk_in),
        .rst_in  (rst_in),
        .ce_in   (ce_in),
        .sh      (sh.shifter)
    );

    // ------------------------------
    // data pin synchroniser: three stages, change taken when 2 and 3 agree
    // ------------------------------
    logic di_s1_q, di_s2_q, di_s3_q, di_q, di_d;

    always_comb begin
        di_d = di_q;
        if (di_s2_q == di_s3_q) begin
            di_d = di_s3_q;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            di_s1_q <= 1'b0;
            di_s2_q <= 1'b0;
            di_s3_q <= 1'b0;
            di_q    <= 1'b0;
        end else if (ce_in) begin
            di_s1_q <= rom_data_pin_in;
            di_s2_q <= di_s1_q;
            di_s3_q <= di_s2_q;
            di_q    <= di_d;
        end
    end

    // ------------------------------
    // controller state
    // ------------------------------
    ctl_state_t  state_q, state_d;
    rom_op_t     op_q, op_d;
    logic [6:0]  loc_q, loc_d;
    logic [7:0]  data_q, data_d;
    logic        busy_q, busy_d;
    logic        to_q, to_d;
    logic        loaded_q, loaded_d;
    logic        load_q, load_d;
    logic [2:0]  idx_q, idx_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic        start_q, start_d;
    logic [31:0] lo_q, lo_d;
    logic [15:0] hi_q, hi_d;

    assign sh.start   = start_q;
    assign sh.di      = di_q;
    assign sh.rd_mode = load_q || op_q == READ_CMD;
    assign sh.nbits   = load_q ? 5'(LONG_BITS) : bits_for(op_q);
    assign sh.frame   = load_q ? build_frame(READ_CMD, {4'h0, idx_q}, data_q)
                               : build_frame(op_q, loc_q, data_q);

    // next values; hardware writes to the address registers win over software
    always_comb begin
        state_d  = state_q;
        op_d     = op_q;
        loc_d    = loc_q;
        data_d   = data_q;
        busy_d   = busy_q;
        to_d     = to_q;
        loaded_d = loaded_q;
        load_d   = load_q;
        idx_d    = idx_q;
        cnt_d    = cnt_q;
        start_d  = 1'b0;
        lo_d     = lo_q;
        hi_d     = hi_q;
        if (addr_low_wr_in) begin
            lo_d = addr_low_in;
        end
        if (addr_high_wr_in) begin
            hi_d = addr_high_in;
        end
        // command and data writes only while idle; a busy command is left alone
        if (!busy_q && cmd_wr_in) begin
            op_d   = rom_op_t'(cmd_op_in);
            loc_d  = cmd_loc_in;
            busy_d = cmd_busy_in;
            if (cmd_busy_in) begin
                to_d = 1'b0;
            end
        end
        if (!busy_q && data_wr_in) begin
            data_d = data_in;
        end
        case (state_q)
            S_IDLE: begin
                if (load_q) begin
                    start_d = 1'b1;
                    state_d = S_SHIFT;
                end else if (busy_q && op_q == RELOAD_CMD) begin
                    load_d   = 1'b1;
                    idx_d    = 3'h0;
                    loaded_d = 1'b0;
                end else if (busy_q) begin
                    start_d = 1'b1;
                    state_d = S_SHIFT;
                end
            end
            S_SHIFT: begin
                if (sh.done) begin
                    state_d = S_IDLE;
                    if (load_q && idx_q == 3'h0) begin
                        if (sh.rdata == SIGNATURE) begin
                            idx_d = 3'h1;
                        end else begin
                            load_d = 1'b0; // address untouched
                            busy_d = 1'b0;
                        end
                    end else if (load_q) begin
                        case (idx_q)
                            3'h1:    lo_d[7:0]   = sh.rdata;
                            3'h2:    lo_d[15:8]  = sh.rdata;
                            3'h3:    lo_d[23:16] = sh.rdata;
                            3'h4:    lo_d[31:24] = sh.rdata;
                            3'h5:    hi_d[7:0]   = sh.rdata;
                            default: hi_d[15:8]  = sh.rdata;
                        endcase // bytes 0..5 in order
                        if (idx_q == MAC_LAST_IDX) begin
                            load_d   = 1'b0;
                            busy_d   = 1'b0;
                            loaded_d = 1'b1; // after all six bytes
                        end else begin
                            idx_d = idx_q + 3'h1;
                        end
                    end else if (op_q == READ_CMD) begin
                        data_d = sh.rdata; // with busy clearing
                        busy_d = 1'b0;
                    end else if (is_prog(op_q)) begin
                        state_d = S_GAP;
                        cnt_d   = '0;
                    end else begin
                        busy_d = 1'b0;
                    end
                end
            end
            S_GAP: begin
                // select low for one phase before the ready poll
                if (cnt_q == CW'(SCLK_HALF - 1)) begin
                    state_d = S_POLL;
                    cnt_d   = '0;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            S_POLL: begin
                // the synchronised pin still shows the pre-poll level at first
                if (di_q && cnt_q >= CW'(SCLK_HALF)) begin
                    state_d = S_IDLE;
                    busy_d  = 1'b0;
                end else if (cnt_q == CW'(TIMEOUT_CYCLES - 1)) begin
                    state_d = S_IDLE;
                    to_d    = 1'b1;
                    busy_d  = 1'b0;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            default: begin
                state_d = S_IDLE;
                busy_d  = 1'b0;
                load_d  = 1'b0;
            end
        endcase
    end

    // reset starts the address load with busy held high
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_q  <= S_IDLE;
            op_q     <= RELOAD_CMD;
            loc_q    <= 7'h00;
            data_q   <= DATA_RST;
            busy_q   <= BUSY_RST;
            to_q     <= 1'b0;
            loaded_q <= 1'b0;
            load_q   <= 1'b1; // location zero first
            idx_q    <= 3'h0;
            cnt_q    <= '0;
            start_q  <= 1'b0;
            lo_q     <= ADDR_LO_RST;
            hi_q     <= ADDR_HI_RST;
        end else if (ce_in) begin
            state_q  <= state_d;
            op_q     <= op_d;
            loc_q    <= loc_d;
            data_q   <= data_d;
            busy_q   <= busy_d;
            to_q     <= to_d;
            loaded_q <= loaded_d;
            load_q   <= load_d;
            idx_q    <= idx_d;
            cnt_q    <= cnt_d;
            start_q  <= start_d;
            lo_q     <= lo_d;
            hi_q     <= hi_d;
        end
    end

    // ------------------------------
    // pin registers; disabled interface hands pins to general outputs
    // ------------------------------
    logic cs_d, ck_d, dq_d, oe_d;

    always_comb begin
        if (rom_if_disable_in) begin
            cs_d = 1'b0;
            ck_d = gp_clock_value_in;
            dq_d = gp_data_value_in;
            oe_d = 1'b1;
        end else begin
            cs_d = sh.cs || state_q == S_POLL;
            ck_d = sh.sclk;
            dq_d = sh.dout;
            oe_d = sh.oe;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rom_cs_out          <= 1'b0;
            rom_clock_pin_out   <= 1'b0;
            rom_data_pin_out    <= 1'b0;
            rom_data_pin_oe_out <= 1'b0;
        end else if (ce_in) begin
            rom_cs_out          <= cs_d;
            rom_clock_pin_out   <= ck_d;
            rom_data_pin_out    <= dq_d;
            rom_data_pin_oe_out <= oe_d;
        end
    end

    // register views are the state flip-flops themselves
    assign rom_busy_bit_out = busy_q;
    assign rom_timeout_bit_out = to_q;
    assign rom_load_success_bit_out = loaded_q;
    assign rom_operation_code_field_out = op_q;
    assign rom_location_field_out = loc_q;
    assign serial_rom_data_reg_out = data_q;
    assign station_address_low_reg_out = lo_q;
    assign station_address_high_reg_out = hi_q;
endmodule

// file: rtl/rom_pkg.sv
// constants and types for the serial rom address loader
// Notes on behaviour
// - after any reset, read location zero before any host operation runs
// - signature A5h at location zero: copy next six bytes into address bytes 0..5
// - set the loaded flag only after all six address bytes are written
// - no signature: stop and leave the station address untouched
// - reload repeats signature check and six-byte load; fails with flag clear
// - successful reload sets the load success bit
// - host sets busy to start; controller clears busy when done
// - read places fetched byte in data register before busy clears
// - no memory response in 30 ms: abandon and set timeout bit
// - interface disabled: data and clock pins become general outputs
// - erase clears the one location named by the location field
// - bulk erase clears all locations, with timeout as other programming
// - read fetches the location named by the location field
// - write programs the data register into the named location
// - fill programs the data register into every location
// - 10 serial clocks for erase, bulk erase, lock, unlock; 18 for others
// - memory is 128 locations of 8 bits, 7-bit location address
package rom_pkg;

    // ------------------------------
    // timing
    // ------------------------------
    localparam int CLK_MHZ       = 100;
    localparam int TIMEOUT_MS    = 30;
    localparam int TIMEOUT_CYC   = TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int SCLK_HALF_NS  = 80;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;

    // ------------------------------
    // frame layout
    // ------------------------------
    localparam int SHORT_BITS = 10;
    localparam int LONG_BITS  = 18;
    localparam logic [1:0] OPC_READ  = 2'h2;
    localparam logic [1:0] OPC_WRITE = 2'h1;
    localparam logic [1:0] OPC_ERASE = 2'h3;
    localparam logic [1:0] OPC_MISC  = 2'h0;
    localparam logic [6:0] LOC_UNLOCK = 7'h60;
    localparam logic [6:0] LOC_LOCK   = 7'h00;
    localparam logic [6:0] LOC_BULK   = 7'h40;
    localparam logic [6:0] LOC_FILL   = 7'h20;

    // ------------------------------
    // address load and reset values
    // ------------------------------
    localparam logic [7:0]  SIGNATURE    = 8'hA5;
    localparam logic [2:0]  MAC_LAST_IDX = 3'h6;
    localparam logic        BUSY_RST     = 1'b1;
    localparam logic [31:0] ADDR_LO_RST  = 32'h0000_0000;
    localparam logic [15:0] ADDR_HI_RST  = 16'h0000;
    localparam logic [7:0]  DATA_RST     = 8'h00;

    typedef enum logic [2:0] {
        READ_CMD           = 3'h0,
        PROGRAM_LOCK_CMD   = 3'h1,
        PROGRAM_UNLOCK_CMD = 3'h2,
        WRITE_CMD          = 3'h3,
        FILL_ALL_CMD       = 3'h4,
        ERASE_CMD          = 3'h5,
        BULK_ERASE_CMD     = 3'h6,
        RELOAD_CMD         = 3'h7
    } rom_op_t;

endpackage

// file: rtl/rom_shift_if.sv
// carrier between the controller and the serial shifter
`timescale 1ns/1ps
interface rom_shift_if;
    logic        start;
    logic [17:0] frame;
    logic [4:0]  nbits;
    logic        rd_mode;
    logic        di;
    logic        cs;
    logic        sclk;
    logic        dout;
    logic        oe;
    logic        done;
    logic [7:0]  rdata;

    modport ctrl    (output start, frame, nbits, rd_mode, di,
                     input cs, sclk, dout, oe, done, rdata);
    modport shifter (input start, frame, nbits, rd_mode, di,
                     output cs, sclk, dout, oe, done, rdata);
endinterface

// file: rtl/rom_serial_shifter.sv
// serial frame engine: chip select, divided clock, data out and in
`timescale 1ns/1ps
module rom_serial_shifter
    import rom_pkg::*;
#(
    parameter int HALF_CYC = SCLK_HALF_CYC
) (
    // clock, reset, enable
    input  wire logic   mclk_in,
    input  wire logic   rst_in,
    input  wire logic   ce_in,
    // controller side
    rom_shift_if.shifter sh
);
    logic        act_q, act_d;
    logic        sclk_q, sclk_d;
    logic        done_q, done_d;
    logic [7:0]  div_q, div_d;
    logic [4:0]  bit_q, bit_d;
    logic [17:0] sr_q, sr_d;
    logic [7:0]  rd_q, rd_d;

    // ------------------------------
    // next state: bit presented while clock low, sampled at falling edge
    // ------------------------------
    always_comb begin
        act_d  = act_q;
        sclk_d = sclk_q;
        done_d = 1'b0;
        div_d  = div_q;
        bit_d  = bit_q;
        sr_d   = sr_q;
        rd_d   = rd_q;
        if (!act_q) begin
            if (sh.start) begin
                act_d  = 1'b1;
                sclk_d = 1'b0;
                div_d  = 8'h00;
                bit_d  = 5'h00;
                sr_d   = sh.frame; // msb first
            end
        end else if (div_q == 8'(HALF_CYC - 1)) begin
            div_d = 8'h00;
            if (!sclk_q) begin
                sclk_d = 1'b1;
            end else begin
                sclk_d = 1'b0;
                rd_d   = {rd_q[6:0], sh.di};
                sr_d   = {sr_q[16:0], 1'b0};
                if (bit_q == sh.nbits - 5'h01) begin // exact clock count
                    act_d  = 1'b0;
                    done_d = 1'b1;
                end else begin
                    bit_d = bit_q + 5'h01;
                end
            end
        end else begin
            div_d = div_q + 8'h01;
        end
    end

    // ------------------------------
    // registers
    // ------------------------------
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            act_q  <= 1'b0;
            sclk_q <= 1'b0;
            done_q <= 1'b0;
            div_q  <= 8'h00;
            bit_q  <= 5'h00;
            sr_q   <= 18'h00000;
            rd_q   <= 8'h00;
        end else if (ce_in) begin
            act_q  <= act_d;
            sclk_q <= sclk_d;
            done_q <= done_d;
            div_q  <= div_d;
            bit_q  <= bit_d;
            sr_q   <= sr_d;
            rd_q   <= rd_d;
        end
    end

    // the pin is released after the address so the memory can answer
    assign sh.cs    = act_q;
    assign sh.sclk  = sclk_q;
    assign sh.dout  = sr_q[17];
    assign sh.oe    = act_q && (!sh.rd_mode || bit_q < 5'(SHORT_BITS));
    assign sh.done  = done_q;
    assign sh.rdata = rd_q;
endmodule

// file: testbench/rom_model.sv
// behavioural serial rom standing on the far side of the loader
`timescale 1ns/1ps
module rom_model (
    // rom pins
    input  wire logic cs_in,
    input  wire logic sclk_in,
    input  wire logic pin_in,
    output logic      pin_out,
    // stall: memory never reports ready
    input  wire logic hang_in
);
    // ------------------------------
    // storage and frame decode
    // ------------------------------
    logic [7:0] mem [128];
    logic [9:0] sr   = 10'h000;
    logic [7:0] wd   = 8'h00;
    int         n    = 0;
    int         j;
    bit         en   = 1'b0; // powers up locked
    bit         pend = 1'b0;
    initial pin_out = 1'h0;
    // header and write data in, read data out msb first
    always @(posedge sclk_in) begin
        if (cs_in && n < 10) sr = {sr[8:0], pin_in};
        else if (cs_in && sr[8:7] == 2'h2) pin_out = mem[sr[6:0]][17 - n];
        else if (cs_in) wd = {wd[6:0], pin_in};
        if (cs_in) n++;
    end
    // after a programming frame: busy low, ready later unless stalled
    always @(posedge cs_in) begin
        n = 0;
        if (pend) begin
            pend = 1'b0;
            pin_out = 1'h0;
            pin_out <= #500 !hang_in;
        end
    end
    // released line flips so no stale level survives
    always @(negedge cs_in) begin
        pin_out = ~pin_out;
        if (n >= 10 && sr[8:7] == 2'h0 && sr[6:5] == 2'h3) en = 1'b1;
        else if (n >= 10 && sr[8:7] == 2'h0 && sr[6:5] == 2'h0) en = 1'b0;
        else if (n >= 10 && sr[8:7] != 2'h2) begin
            pend = 1'b1;
            for (j = 0; j < 128; j++)
                if (en && !hang_in && (sr[8:7] == 2'h0 || j == sr[6:0]))
                    mem[j] = (sr[8:7] == 2'h3 || sr[8:5] == 4'h2) ? 8'hFF : wd;
        end
    end
endmodule

// file: testbench/serial_rom_mac_loader_props.sv
// port-level checks for the serial rom loader
`timescale 1ns/1ps
module serial_rom_mac_loader_props (
    // clock, reset, inputs
    input wire logic       mclk_in, rst_in, ce_in, cmd_wr_in, cmd_busy_in, data_wr_in,
    input wire logic [2:0] cmd_op_in,
    input wire logic [7:0] data_in,
    input wire logic       rom_if_disable_in, gp_data_value_in, gp_clock_value_in,
    // outputs watched
    input wire logic       rom_busy_bit_out, rom_timeout_bit_out, rom_load_success_bit_out,
    input wire logic [2:0] rom_operation_code_field_out,
    input wire logic [6:0] rom_location_field_out,
    input wire logic [7:0] serial_rom_data_reg_out,
    input wire logic       rom_cs_out, rom_clock_pin_out, rom_data_pin_out, rom_data_pin_oe_out
);
    // ------------------------------
    // clock rises counted per chip-select window
    // ------------------------------
    logic [4:0] edges_q = 5'h00;
    logic [4:0] edges_d;
    logic       clk_q   = 1'h0;
    always_comb begin
        edges_d = rom_cs_out ? edges_q + {4'h0, rom_clock_pin_out & ~clk_q} : 5'h00;
    end
    always_ff @(posedge mclk_in) begin
        edges_q <= edges_d;
        clk_q   <= rom_clock_pin_out;
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    AST_BUSY_AFTER_RESET: assert property ($fell(rst_in) |-> rom_busy_bit_out[*8])
        else $error("busy low right after reset");
    AST_LOADED_AT_END: assert property ($rose(rom_load_success_bit_out) |->
        $fell(rom_busy_bit_out)) else $error("loaded flag not with busy clear");
    AST_TIMEOUT_FREES: assert property ($rose(rom_timeout_bit_out) |->
        $fell(rom_busy_bit_out)) else $error("timeout without busy clear");
    AST_CMD_TAKEN: assert property (ce_in && cmd_wr_in && cmd_busy_in && !rom_busy_bit_out |=>
        rom_busy_bit_out && !rom_timeout_bit_out
        && rom_operation_code_field_out == $past(cmd_op_in)) else $error("command not taken");
    AST_CMD_REFUSED: assert property (rom_busy_bit_out && cmd_wr_in |=>
        $stable(rom_location_field_out)) else $error("command changed while busy");
    AST_DATA_WRITE: assert property (ce_in && data_wr_in && !rom_busy_bit_out |=>
        serial_rom_data_reg_out == $past(data_in)) else $error("data write lost");
    AST_IDLE_NO_SELECT: assert property (!rom_busy_bit_out[*3] |-> !rom_cs_out)
        else $error("select while idle");
    AST_FRAME_CLOCKS: assert property ($fell(rom_cs_out) && !rom_if_disable_in |->
        edges_q inside {5'h00, 5'h0A, 5'h12}) else $error("bad clock count");
    AST_DISABLED_PINS: assert property (ce_in && rom_if_disable_in |=> rom_data_pin_oe_out
        && !rom_cs_out && rom_data_pin_out == $past(gp_data_value_in)
        && rom_clock_pin_out == $past(gp_clock_value_in)) else $error("pins not general");
endmodule
bind serial_rom_mac_loader serial_rom_mac_loader_props u_props (.*);

// file: testbench/serial_rom_mac_loader_bench.sv
// self-checking bench for the serial rom address loader
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module serial_rom_mac_loader_bench
    import rom_pkg::*;
;
    // ------------------------------
    // stimulus, expected state, design and rom
    // ------------------------------
    logic        mclk_in = 1'h0, rst_in = 1'h1, cmd_wr_in = 1'h0, cmd_busy_in = 1'h0;
    logic        data_wr_in = 1'h0, addr_wr = 1'h0, hang = 1'h0, dis = 1'h0;
    logic [1:0]  gp = 2'h0;
    logic [2:0]  cmd_op_in = 3'h0;
    logic [6:0]  cmd_loc_in = 7'h00;
    logic [7:0]  data_in = 8'h00, rdata;
    logic [47:0] sw_addr = 48'h9ABC_1234_5678, exp_addr;
    logic [7:0]  exp_mem [128];
    logic        busy, tout, loaded, cs, sclk, dpin, doe, din;
    logic [31:0] lo;
    logic [15:0] hi;
    wire         pin = doe ? dpin : din;
    int          n_fail = 0, comparisons = 0, seed = 32'h4cb6, i;
    bit          unlocked = 1'b0;
    serial_rom_mac_loader #(.TIMEOUT_CYCLES(200)) u_dut (.mclk_in, .rst_in, .ce_in(1'h1),
        .cmd_wr_in, .cmd_op_in, .cmd_loc_in, .cmd_busy_in, .data_wr_in, .data_in,
        .addr_low_wr_in(addr_wr), .addr_low_in(sw_addr[31:0]), .addr_high_wr_in(addr_wr),
        .addr_high_in(sw_addr[47:32]), .rom_if_disable_in(dis), .gp_data_value_in(gp[1]),
        .gp_clock_value_in(gp[0]), .rom_busy_bit_out(busy), .rom_timeout_bit_out(tout),
        .rom_load_success_bit_out(loaded), .rom_operation_code_field_out(),
        .rom_location_field_out(), .serial_rom_data_reg_out(rdata),
        .station_address_low_reg_out(lo), .station_address_high_reg_out(hi),
        .rom_cs_out(cs), .rom_clock_pin_out(sclk), .rom_data_pin_out(dpin),
        .rom_data_pin_oe_out(doe), .rom_data_pin_in(pin));
    rom_model u_rom (.cs_in(cs), .sclk_in(sclk), .pin_in(pin), .pin_out(din), .hang_in(hang));
    initial begin
        forever #5 mclk_in = ~mclk_in;
    end
    task automatic conclude;
        if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // bounded wait for busy to clear
    task automatic idle;
        int k;
        for (k = 0; busy !== 1'h0; k++) begin
            if (k == 20000) begin n_fail++; conclude(); end
            @(negedge mclk_in);
        end
    endtask
    // data register, then command; the model follows the same operation
    task automatic cmd(input rom_op_t op, input logic [6:0] a, input logic [7:0] d);
        int  j;
        logic prog;
        prog = op inside {WRITE_CMD, FILL_ALL_CMD, ERASE_CMD, BULK_ERASE_CMD};
        @(negedge mclk_in);
        data_in = d;
        data_wr_in = 1'h1;
        @(negedge mclk_in);
        data_wr_in = 1'h0;
        {cmd_op_in, cmd_loc_in, cmd_busy_in, cmd_wr_in} = {op, a, 2'h3};
        @(negedge mclk_in);
        cmd_wr_in = 1'h0;
        idle();
        if (op inside {PROGRAM_UNLOCK_CMD, PROGRAM_LOCK_CMD}) unlocked = (op == PROGRAM_UNLOCK_CMD);
        for (j = 0; j < 128; j++)
            if (prog && unlocked && !hang && (j == a || op inside {FILL_ALL_CMD, BULK_ERASE_CMD}))
                exp_mem[j] = op inside {WRITE_CMD, FILL_ALL_CMD} ? d : 8'hFF;
        `CHK(tout, prog && hang)
        if (op == READ_CMD) `CHK(rdata, exp_mem[a])
        if (op == RELOAD_CMD) begin
            for (j = 0; j < 6 && exp_mem[0] == SIGNATURE; j++) exp_addr[8*j+:8] = exp_mem[j+1];
            `CHK(loaded, exp_mem[0] == SIGNATURE)
            `CHK({hi, lo}, exp_addr)
        end
    endtask
    initial begin
        #400_000;
        n_fail++;
        conclude();
    end
    initial begin
        for (i = 0; i < 128; i++) exp_mem[i] = 8'($random(seed));
        exp_mem[0] = SIGNATURE;
        u_rom.mem = exp_mem;
        repeat (12) @(negedge mclk_in);
        rst_in = 1'h0;
        idle();
        for (i = 0; i < 6; i++) exp_addr[8*i+:8] = exp_mem[i+1];
        `CHK(loaded, 1'h1)
        `CHK({hi, lo}, exp_addr)
        for (i = 0; i < 6; i++) cmd(READ_CMD, i ? 7'($random(seed)) : 7'h7F, 8'h00);
        cmd(WRITE_CMD, 7'h05, 8'h3C);
        cmd(READ_CMD, 7'h05, 8'h00);
        cmd(PROGRAM_UNLOCK_CMD, 7'h00, 8'h00);
        for (i = 0; i < 6; i++) begin
            cmd(i % 2 ? ERASE_CMD : WRITE_CMD, 7'(i * 23), 8'($random(seed)));
            cmd(READ_CMD, 7'(i * 23), 8'h00);
        end
        addr_wr = 1'h1;
        @(negedge mclk_in);
        addr_wr = 1'h0;
        exp_addr = sw_addr;
        cmd(FILL_ALL_CMD, 7'h00, 8'h5A);
        cmd(READ_CMD, 7'h44, 8'h00);
        cmd(RELOAD_CMD, 7'h00, 8'h00);
        cmd(BULK_ERASE_CMD, 7'h00, 8'h00);
        cmd(READ_CMD, 7'h13, 8'h00);
        for (i = 0; i < 7; i++) cmd(WRITE_CMD, 7'(i), i ? 8'($random(seed)) : SIGNATURE);
        cmd(RELOAD_CMD, 7'h00, 8'h00);
        hang = 1'h1;
        cmd(ERASE_CMD, 7'h02, 8'h11);
        hang = 1'h0;
        cmd(PROGRAM_LOCK_CMD, 7'h00, 8'h00);
        cmd(WRITE_CMD, 7'h03, 8'hC3);
        cmd(READ_CMD, 7'h03, 8'h00);
        dis = 1'h1;
        for (i = 0; i < 4; i++) begin
            gp = 2'(i);
            repeat (2) @(negedge mclk_in);
            `CHK({dpin, sclk, doe, cs}, {gp, 2'h2})
        end
        conclude();
    end
endmodule
